// *** src/mrb_bank_mem.v ***
`timescale 1ns/100ps
// Per-bank storage of value and time stamp, registered read
module mrb_bank_mem #(
  parameter DW = 32,
  parameter AW = 4
) (
  input wire clk, // Clock
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write address
  input wire [DW-1:0] wdata, // Write data
  input wire [AW-1:0] raddr, // Read address
  output reg [DW-1:0] rdata // Registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mrb_bank_mem

// *** src/mrb_defs.vh ***
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH
// Bank update operations
`define MRB_UPD_WRITE 3'h0
`define MRB_UPD_ADD 3'h1
`define MRB_UPD_MAX1 3'h2
`define MRB_UPD_MAXACC 3'h3
`define MRB_UPD_MAX2 3'h4
`define MRB_UPD_AVG2 3'h5
`define MRB_UPD_MAX3 3'h6
`define MRB_UPD_AVG3 3'h7
// Billing close operations
`define MRB_BIL_WRITE 2'h0
`define MRB_BIL_ADD 2'h1
`define MRB_BIL_WRITE_CLR 2'h2
`define MRB_BIL_ADD_CLR 2'h3
// Result type and billing close source
`define MRB_TYPE_ENERGY 1'b0
`define MRB_TYPE_POWER 1'b1
`define MRB_SRC_ALARM 1'b0
`define MRB_SRC_EXT 1'b1
// Level select for output scaling
`define MRB_LEV0 2'h0
`define MRB_LEV1 2'h1
`define MRB_LEV2 2'h2
// Seconds per hour
`define MRB_SEC_PER_HOUR 32'd3600
// Hysteresis reset value
`define MRB_HYST_RESET 32'h0
// Entry slots of a bank set
`define MRB_SLOT_MAIN 2'h0
`define MRB_SLOT_M2 2'h1
`define MRB_SLOT_M3 2'h2
`endif

// *** src/mrb_engine.v ***
`timescale 1ns/100ps
`include "mrb_defs.vh"
module mrb_engine #(
  parameter DW = 32, // Result width
  parameter NOUT = 2, // Impulse outputs
  parameter NBANK = 2 // Billing banks
) (
  input wire CLK, // Clock
  input wire RESETN, // Sync reset, active low
  input wire RAW_VALID, // New raw function result
  input wire signed [DW-1:0] RAW_FUNCTION_RESULT, // Raw level 2 result
  input wire [DW-1:0] HYST, // Hysteresis value
  output reg signed [DW-1:0] FILTERED_FUNCTION_RESULT, // Filtered result
  input wire [3*DW-1:0] LEVEL_DELTA, // Increments of levels 0,1,2 packed
  input wire LEVEL_VALID, // Increments valid
  input wire [2*NOUT-1:0] OUT_LEVEL_SEL, // Level select per output
  input wire [DW*NOUT-1:0] OUT_NUM, // Numerator per output
  input wire [DW*NOUT-1:0] OUT_DEN, // Denominator per output
  input wire [DW*NOUT-1:0] OUT_PULSE_QUANT, // Amount per pulse
  input wire [NOUT-1:0] PULSE_ACK, // Pulse taken by generator
  output wire [NOUT-1:0] PULSE_REQ, // Pulse request
  output reg [DW*NOUT-1:0] OUTPUT_SCALED_RESULT, // Scaled results
  input wire [3*DW-1:0] PERIOD_RESULT, // Last completed period results, levels 0..2
  input wire PERIOD_END, // Measuring period end strobe
  input wire [DW-1:0] PERIOD_LENGTH_SECONDS, // Measuring period length
  input wire [DW-1:0] TIME_NOW, // Time stamp source
  input wire [2*NBANK-1:0] BANK_LEVEL_SEL, // Level per bank
  input wire [NBANK-1:0] BANK_TYPE, // Energy or power per bank
  input wire [NBANK-1:0] BANK_UPD_EN, // Bank uses this period end
  input wire [3*NBANK-1:0] BANK_UPD_OP, // Update operation per bank
  input wire [NBANK-1:0] BANK_SRC, // Billing close source
  input wire [2*NBANK-1:0] BANK_BIL_OP, // Billing operation per bank
  input wire ALARM, // Repeatable time alarm pulse
  input wire EXT_PULSE, // External billing pulse pin
  input wire [NBANK-1:0] RD_SEL_LAST, // Read last set per bank
  input wire [2*NBANK-1:0] RD_SLOT, // Read slot per bank
  output wire [DW*NBANK-1:0] BANK_VALUE, // Read value per bank
  output wire [DW*NBANK-1:0] BANK_STAMP // Read stamp per bank
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DIV = 3'b010;
  localparam ST_DONE = 3'b100;
  localparam [5:0] DIV_STEPS = DW + 12;
  // External pulse synchroniser
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  always @(posedge CLK) begin
    if (!RESETN) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= EXT_PULSE;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  wire ext_edge = ext_s2 & ~ext_s3;
  // Hysteresis window; tracker is internal only
  reg signed [DW-1:0] tracker;
  reg signed [DW-1:0] prev_raw;
  reg signed [DW-1:0] next_tracker;
  reg signed [DW-1:0] next_filt;
  reg signed [DW-1:0] d;
  reg signed [DW-1:0] t;
  wire signed [DW-1:0] win = $signed({HYST[DW-2:0], 1'b0});
  always @* begin
    d = RAW_FUNCTION_RESULT - prev_raw;
    t = tracker + d;
    next_tracker = t;
    next_filt = FILTERED_FUNCTION_RESULT;
    if (HYST == `MRB_HYST_RESET) begin
      next_tracker = {DW{1'b0}};
      next_filt = RAW_FUNCTION_RESULT;
    end else if (t > win) begin
      next_tracker = win;
      next_filt = FILTERED_FUNCTION_RESULT + (t - win);
    end else if (t < 0) begin
      next_tracker = {DW{1'b0}};
      next_filt = FILTERED_FUNCTION_RESULT + t;
    end
    // Inside window filtered holds, limits stay
  end
  always @(posedge CLK) begin
    if (!RESETN) begin
      tracker <= {DW{1'b0}};
      prev_raw <= {DW{1'b0}};
      FILTERED_FUNCTION_RESULT <= {DW{1'b0}};
    end else if (RAW_VALID) begin
      tracker <= next_tracker;
      prev_raw <= RAW_FUNCTION_RESULT;
      FILTERED_FUNCTION_RESULT <= next_filt;
    end
  end
  // Output scaling, one channel per impulse output
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_out
      wire [1:0] sel = OUT_LEVEL_SEL[2*g+1:2*g];
      wire signed [DW-1:0] src = (sel == `MRB_LEV0) ? $signed(LEVEL_DELTA[DW-1:0]) :
        (sel == `MRB_LEV1) ? $signed(LEVEL_DELTA[2*DW-1:DW]) : $signed(LEVEL_DELTA[3*DW-1:2*DW]);
      wire signed [DW-1:0] num = $signed(OUT_NUM[DW*g+DW-1:DW*g]);
      wire signed [DW-1:0] den = $signed(OUT_DEN[DW*g+DW-1:DW*g]);
      wire signed [2*DW-1:0] prod = src * num;
      wire signed [2*DW-1:0] quo = (den == 0) ? {2*DW{1'b0}} : prod / den;
      wire signed [DW-1:0] q = $signed(OUT_PULSE_QUANT[DW*g+DW-1:DW*g]);
      reg signed [DW-1:0] acc;
      reg signed [DW-1:0] next_acc;
      assign PULSE_REQ[g] = ~acc[DW-1] && (q > 0) && (acc >= q);
      always @* begin
        next_acc = acc;
        if (LEVEL_VALID) begin
          next_acc = next_acc + quo[DW-1:0];
        end
        if (PULSE_REQ[g] && PULSE_ACK[g]) begin
          next_acc = next_acc - q;
        end
      end
      always @(posedge CLK) begin
        if (!RESETN) begin
          acc <= {DW{1'b0}};
          OUTPUT_SCALED_RESULT[DW*g+DW-1:DW*g] <= {DW{1'b0}};
        end else begin
          acc <= next_acc;
          OUTPUT_SCALED_RESULT[DW*g+DW-1:DW*g] <= next_acc;
        end
      end
    end
  endgenerate
  // Billing banks
  generate
    for (g = 0; g < NBANK; g = g + 1) begin : g_bank
      wire [1:0] lsel = BANK_LEVEL_SEL[2*g+1:2*g];
      wire [DW-1:0] pin = (lsel == `MRB_LEV0) ? PERIOD_RESULT[DW-1:0] :
        (lsel == `MRB_LEV1) ? PERIOD_RESULT[2*DW-1:DW] : PERIOD_RESULT[3*DW-1:2*DW];
      wire [2:0] op = BANK_UPD_OP[3*g+2:3*g];
      wire [1:0] bop = BANK_BIL_OP[2*g+1:2*g];
      reg [2:0] state;
      reg [DW+11:0] dividend;
      reg [DW-1:0] quot;
      reg [DW+11:0] rem;
      reg [5:0] cnt;
      reg [DW-1:0] newv;
      reg [DW-1:0] cur0;
      reg [DW-1:0] cur1;
      reg [DW-1:0] cur2;
      reg [DW-1:0] st0;
      reg [DW-1:0] st1;
      reg [DW-1:0] st2;
      reg [DW-1:0] last0;
      reg [DW-1:0] lst0;
      reg bill_pend;
      reg [DW-1:0] next_cur0;
      reg [DW-1:0] next_cur1;
      reg [DW-1:0] next_cur2;
      reg [DW+1:0] sum3;
      wire close_ev = (BANK_SRC[g] == `MRB_SRC_EXT) ? ext_edge : ALARM;
      wire upd_go = PERIOD_END & BANK_UPD_EN[g];
      // Power = value * 3600 / period seconds, serial divider
      always @(posedge CLK) begin
        if (!RESETN) begin
          state <= ST_IDLE;
          dividend <= {(DW+12){1'b0}};
          quot <= {DW{1'b0}};
          rem <= {(DW+12){1'b0}};
          cnt <= 6'h0;
          newv <= {DW{1'b0}};
        end else begin
          case (state)
            ST_IDLE: begin
              if (upd_go) begin
                if (BANK_TYPE[g] == `MRB_TYPE_POWER && PERIOD_LENGTH_SECONDS != 0) begin
                  dividend <= pin * `MRB_SEC_PER_HOUR;
                  rem <= {(DW+12){1'b0}};
                  cnt <= DIV_STEPS;
                  state <= ST_DIV;
                end else begin
                  newv <= pin;
                  state <= ST_DONE;
                end
              end
            end
            ST_DIV: begin
              if (cnt == 6'h0) begin
                newv <= quot;
                state <= ST_DONE;
              end else begin
                if ({rem[DW+10:0], dividend[DW+11]} >= {12'h0, PERIOD_LENGTH_SECONDS}) begin
                  rem <= {rem[DW+10:0], dividend[DW+11]} - {12'h0, PERIOD_LENGTH_SECONDS};
                  quot <= {quot[DW-2:0], 1'b1};
                end else begin
                  rem <= {rem[DW+10:0], dividend[DW+11]};
                  quot <= {quot[DW-2:0], 1'b0};
                end
                dividend <= {dividend[DW+10:0], 1'b0};
                cnt <= cnt - 6'h1;
              end
            end
            ST_DONE: begin
              state <= ST_IDLE;
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end
      always @* begin
        next_cur0 = cur0;
        next_cur1 = cur1;
        next_cur2 = cur2;
        sum3 = {2'b00, cur0} + {2'b00, cur1} + {2'b00, cur2};
        case (op)
          `MRB_UPD_WRITE: next_cur0 = newv;
          `MRB_UPD_ADD: next_cur0 = cur0 + newv;
          `MRB_UPD_MAX1: begin
            if (newv > cur0) begin
              next_cur0 = newv;
              next_cur1 = cur0;
              next_cur2 = cur1;
            end
          end
          `MRB_UPD_MAXACC: begin
            if (newv > cur0) begin
              next_cur0 = cur0 + newv;
            end
          end
          `MRB_UPD_MAX2, `MRB_UPD_AVG2: begin
            if (newv > cur1 && newv < cur0) begin
              next_cur1 = newv;
              next_cur2 = cur1;
            end
          end
          `MRB_UPD_MAX3, `MRB_UPD_AVG3: begin
            if (newv > cur2 && newv < cur1) begin
              next_cur2 = newv;
            end
          end
          default: next_cur0 = cur0;
        endcase
      end
      // Average reads of the peak slots
      wire [DW:0] sum2 = {1'b0, cur0} + {1'b0, cur1};
      wire [DW-1:0] two_peak_average = sum2[DW:1];
      wire [DW+1:0] avg3 = sum3 / 3;
      wire [DW-1:0] three_peak_average = avg3[DW-1:0];
      wire bill_now = (bill_pend | close_ev) & (state == ST_IDLE) & ~upd_go;
      always @(posedge CLK) begin
        if (!RESETN) begin
          cur0 <= {DW{1'b0}};
          cur1 <= {DW{1'b0}};
          cur2 <= {DW{1'b0}};
          st0 <= {DW{1'b0}};
          st1 <= {DW{1'b0}};
          st2 <= {DW{1'b0}};
          last0 <= {DW{1'b0}};
          lst0 <= {DW{1'b0}};
          bill_pend <= 1'b0;
        end else begin
          if (state == ST_DONE) begin
            cur0 <= next_cur0;
            cur1 <= next_cur1;
            cur2 <= next_cur2;
            if (next_cur0 != cur0) st0 <= TIME_NOW;
            if (next_cur1 != cur1) st1 <= TIME_NOW;
            if (next_cur2 != cur2) st2 <= TIME_NOW;
          end
          if (bill_now) begin
            bill_pend <= 1'b0;
            lst0 <= TIME_NOW;
            if (bop == `MRB_BIL_WRITE || bop == `MRB_BIL_WRITE_CLR) begin
              last0 <= (op == `MRB_UPD_AVG2) ? two_peak_average :
                (op == `MRB_UPD_AVG3) ? three_peak_average : cur0;
            end else begin
              last0 <= last0 + ((op == `MRB_UPD_AVG2) ? two_peak_average :
                (op == `MRB_UPD_AVG3) ? three_peak_average : cur0);
            end
            if (bop == `MRB_BIL_WRITE_CLR || bop == `MRB_BIL_ADD_CLR) begin
              cur0 <= {DW{1'b0}};
              cur1 <= {DW{1'b0}};
              cur2 <= {DW{1'b0}};
            end
          end else if (close_ev) begin
            bill_pend <= 1'b1;
          end
        end
      end
      // Read mux into a registered memory per bank
      wire [1:0] rs = RD_SLOT[2*g+1:2*g];
      wire [DW-1:0] rv = RD_SEL_LAST[g] ? last0 : (rs == `MRB_SLOT_M2) ? cur1 :
        (rs == `MRB_SLOT_M3) ? cur2 : cur0;
      wire [DW-1:0] rt = RD_SEL_LAST[g] ? lst0 : (rs == `MRB_SLOT_M2) ? st1 :
        (rs == `MRB_SLOT_M3) ? st2 : st0;
      mrb_bank_mem #(.DW(2*DW), .AW(1)) u_mem (
        .clk(CLK),
        .we(1'b1),
        .waddr(1'b0),
        .wdata({rt, rv}),
        .raddr(1'b0),
        .rdata({BANK_STAMP[DW*g+DW-1:DW*g], BANK_VALUE[DW*g+DW-1:DW*g]})
      );
    end
  endgenerate
endmodule // mrb_engine

// *** tb/mrb_engine_properties.sv ***
`timescale 1ns/100ps
module mrb_engine_chk #(
  parameter DW = 32,
  parameter NOUT = 2
) (
  input wire CLK, // Clock
  input wire RESETN, // Reset
  input wire RAW_VALID, // Raw strobe
  input wire signed [DW-1:0] RAW_FUNCTION_RESULT, // Raw
  input wire [DW-1:0] HYST, // Hysteresis
  input wire signed [DW-1:0] FILTERED_FUNCTION_RESULT, // Filtered
  input wire [3*DW-1:0] LEVEL_DELTA, // Increments
  input wire LEVEL_VALID, // Increment strobe
  input wire [2*NOUT-1:0] OUT_LEVEL_SEL, // Levels
  input wire [DW*NOUT-1:0] OUT_NUM, // Numerators
  input wire [DW*NOUT-1:0] OUT_DEN, // Denominators
  input wire [DW*NOUT-1:0] OUT_PULSE_QUANT, // Pulse amounts
  input wire [NOUT-1:0] PULSE_ACK, // Taken
  input wire [NOUT-1:0] PULSE_REQ, // Request
  input wire [DW*NOUT-1:0] OUTPUT_SCALED_RESULT // Scaled
);
  reg hyst_seen;
  wire signed [DW-1:0] acc0 = OUTPUT_SCALED_RESULT[DW-1:0];
  wire signed [DW-1:0] acc1 = OUTPUT_SCALED_RESULT[2*DW-1:DW];
  wire signed [DW-1:0] q0 = OUT_PULSE_QUANT[DW-1:0];
  wire signed [DW-1:0] q1 = OUT_PULSE_QUANT[2*DW-1:DW];
  // Nonzero hysteresis seen since reset
  always @(posedge CLK) begin
    if (!RESETN) begin
      hyst_seen <= 1'b0;
    end else if (HYST != 0) begin
      hyst_seen <= 1'b1;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_zero_hyst;
    RAW_VALID && HYST == 0 && !hyst_seen |=> FILTERED_FUNCTION_RESULT == $past(RAW_FUNCTION_RESULT);
  endproperty
  a_zero_hyst: assert property (p_zero_hyst) else $error("filtered differs from raw");
  property p_filt_hold;
    !RAW_VALID |=> $stable(FILTERED_FUNCTION_RESULT);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filtered moved without sample");
  property p_req_nonneg;
    PULSE_REQ[0] |-> acc0 >= 0;
  endproperty
  a_req_nonneg: assert property (p_req_nonneg) else $error("request on negative result");
  property p_req_quota;
    PULSE_REQ[0] |-> q0 > 0 && acc0 >= q0;
  endproperty
  a_req_quota: assert property (p_req_quota) else $error("request below pulse amount");
  property p_req_pair;
    PULSE_REQ[1] |-> q1 > 0 && acc1 >= q1 && acc1 >= 0;
  endproperty
  a_req_pair: assert property (p_req_pair) else $error("second output request wrong");
  property p_ack_sub;
    PULSE_ACK[0] && PULSE_REQ[0] && !LEVEL_VALID |=> acc0 == $past(acc0) - $past(q0);
  endproperty
  a_ack_sub: assert property (p_ack_sub) else $error("pulse not subtracted");
  property p_still;
    !LEVEL_VALID && !PULSE_ACK[0] |=> $stable(acc0);
  endproperty
  a_still: assert property (p_still) else $error("scaled result moved");
  property p_scale;
    LEVEL_VALID && !PULSE_ACK[0] && OUT_LEVEL_SEL[1:0] == 2'h0 && OUT_DEN[DW-1:0] == 1
      |=> acc0 == $past(acc0) + $past(LEVEL_DELTA[DW-1:0]) * $past(OUT_NUM[DW-1:0]);
  endproperty
  a_scale: assert property (p_scale) else $error("scaled sum wrong");
endmodule // mrb_engine_chk
bind mrb_engine mrb_engine_chk #(.DW(DW), .NOUT(NOUT)) u_chk (.CLK(CLK), .RESETN(RESETN), .RAW_VALID(RAW_VALID),
  .RAW_FUNCTION_RESULT(RAW_FUNCTION_RESULT), .HYST(HYST), .FILTERED_FUNCTION_RESULT(FILTERED_FUNCTION_RESULT),
  .LEVEL_DELTA(LEVEL_DELTA), .LEVEL_VALID(LEVEL_VALID), .OUT_LEVEL_SEL(OUT_LEVEL_SEL), .OUT_NUM(OUT_NUM),
  .OUT_DEN(OUT_DEN), .OUT_PULSE_QUANT(OUT_PULSE_QUANT), .PULSE_ACK(PULSE_ACK), .PULSE_REQ(PULSE_REQ),
  .OUTPUT_SCALED_RESULT(OUTPUT_SCALED_RESULT));

// *** tb/mrb_engine_test.sv ***
`timescale 1ns/100ps
`include "mrb_defs.vh"
module mrb_engine_test;
  localparam DW = 32;
  localparam [55:0] HSEQ = 56'h14_08_06_09_07_ff_fd;
  localparam [11:0] OPS = {`MRB_UPD_ADD, `MRB_UPD_MAXACC, `MRB_UPD_MAX1, `MRB_UPD_WRITE};
  reg CLK = 1'b0;
  reg RESETN = 1'b0;
  reg raw_valid = 1'b0;
  reg lev_valid = 1'b0;
  reg per_end = 1'b0;
  reg alarm = 1'b0;
  reg ext = 1'b0;
  reg [DW-1:0] raw = 32'h0;
  reg [DW-1:0] hyst = 32'h0;
  reg [DW-1:0] now = 32'h0;
  reg [3*DW-1:0] delta = 96'h0;
  reg [3*DW-1:0] per_res = 96'h0;
  reg [2:0] upd_op = 3'h0;
  reg [1:0] rd_last = 2'h0;
  reg [3:0] out_sel = 4'h8;
  reg [DW-1:0] per_len = 32'h384;
  reg [3:0] bank_lsel = 4'h0;
  reg [1:0] bank_type = 2'h0;
  reg [1:0] upd_en = 2'h3;
  reg [1:0] bank_src = 2'h2;
  reg [3:0] bil_op = {`MRB_BIL_WRITE, `MRB_BIL_WRITE_CLR};
  reg [3:0] rd_slot = 4'h0;
  reg [3:0] gap0 = 4'h0;
  reg [3:0] gap1 = 4'h5;
  reg [31:0] seed = 32'h61dc;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer cyc = 0;
  wire [DW-1:0] filt;
  wire [1:0] req;
  wire [1:0] ack;
  wire [2*DW-1:0] scaled;
  wire [2*DW-1:0] bval;
  wire [15:0] cnt0;
  wire [15:0] cnt1;
  mrb_engine #(.DW(DW), .NOUT(2), .NBANK(2)) DUT (.CLK(CLK), .RESETN(RESETN), .RAW_VALID(raw_valid),
    .RAW_FUNCTION_RESULT(raw), .HYST(hyst), .FILTERED_FUNCTION_RESULT(filt), .LEVEL_DELTA(delta),
    .LEVEL_VALID(lev_valid), .OUT_LEVEL_SEL(out_sel), .OUT_NUM({32'h2, 32'h3}), .OUT_DEN({32'h2, 32'h1}),
    .OUT_PULSE_QUANT({32'h7, 32'ha}), .PULSE_ACK(ack), .PULSE_REQ(req), .OUTPUT_SCALED_RESULT(scaled),
    .PERIOD_RESULT(per_res), .PERIOD_END(per_end), .PERIOD_LENGTH_SECONDS(per_len), .TIME_NOW(now),
    .BANK_LEVEL_SEL(bank_lsel), .BANK_TYPE(bank_type), .BANK_UPD_EN(upd_en), .BANK_UPD_OP({upd_op, upd_op}),
    .BANK_SRC(bank_src), .BANK_BIL_OP(bil_op), .ALARM(alarm), .EXT_PULSE(ext),
    .RD_SEL_LAST(rd_last), .RD_SLOT(rd_slot), .BANK_VALUE(bval), .BANK_STAMP());
  mrb_pulse_gen u_gen0 (.CLK(CLK), .RESETN(RESETN), .REQ(req[0]), .GAP(gap0), .ACK(ack[0]), .COUNT(cnt0));
  mrb_pulse_gen u_gen1 (.CLK(CLK), .RESETN(RESETN), .REQ(req[1]), .GAP(gap1), .ACK(ack[1]), .COUNT(cnt1));
  always #2 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    now <= now + 32'h1;
    if (cyc == 8000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [DW-1:0] upd(input [2:0] op, input [DW-1:0] c, input [DW-1:0] v);
    case (op)
      `MRB_UPD_WRITE: upd = v;
      `MRB_UPD_ADD: upd = c + v;
      `MRB_UPD_MAX1: upd = (v > c) ? v : c;
      default: upd = (v > c) ? c + v : c;
    endcase
  endfunction
  task check(input [DW-1:0] seen, input [DW-1:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task hyst_phase(input [DW-1:0] h);
    integer i;
    integer t;
    integer w;
    reg [7:0] b;
    reg signed [DW-1:0] v;
    reg signed [DW-1:0] last;
    reg signed [DW-1:0] ef;
    t = 0;
    w = 2 * h;
    last = 0;
    ef = 0;
    @(posedge CLK);
    RESETN <= 1'b0;
    hyst <= h;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      seed = lfsr(seed);
      b = (i < 7) ? HSEQ[8*i +: 8] : seed[7:0];
      v = {{24{b[7]}}, b};
      t = t + v - last;
      last = v;
      if (t > w) begin
        ef = ef + t - w;
        t = w;
      end else if (t < 0) begin
        ef = ef + t;
        t = 0;
      end
      @(posedge CLK);
      raw <= v;
      raw_valid <= 1'b1;
      @(posedge CLK);
      raw_valid <= 1'b0;
      @(posedge CLK);
      #1;
      check(filt, ef);
    end
  endtask
  task lev(input [3*DW-1:0] d);
    @(posedge CLK);
    delta <= d;
    lev_valid <= 1'b1;
    @(posedge CLK);
    lev_valid <= 1'b0;
  endtask
  task scale_phase;
    integer i;
    integer tot0;
    integer tot1;
    tot0 = 0;
    tot1 = -5;
    lev({32'hfffffffb, 64'h0});
    repeat (3) @(posedge CLK);
    #1;
    check(scaled[63:32], 32'hfffffffb);
    check({30'h0, req}, 32'h0);
    for (i = 0; i < 20; i = i + 1) begin
      seed = lfsr(seed);
      lev({28'h0, seed[11:8], 24'h0, seed[23:16], 28'h0, seed[3:0]});
      tot0 = tot0 + 3 * seed[3:0];
      tot1 = tot1 + seed[11:8];
      repeat (seed[25:24]) @(posedge CLK);
    end
    #1;
    for (i = 0; i < 400 && req !== 2'h0; i = i + 1) begin
      @(posedge CLK);
      #1;
    end
    check(scaled[31:0], tot0 - 10 * cnt0);
    check({16'h0, cnt0}, tot0 / 10);
    check(scaled[63:32], tot1 - 7 * cnt1);
    check({16'h0, cnt1}, tot1 / 7);
  endtask
  task rd(input l);
    @(posedge CLK);
    rd_last <= {l, l};
    repeat (4) @(posedge CLK);
    #1;
  endtask
  task bank_phase;
    integer j;
    reg [DW-1:0] cur;
    reg [DW-1:0] v;
    cur = 32'h0;
    for (j = 0; j < 16; j = j + 1) begin
      seed = lfsr(seed);
      v = {24'h0, seed[7:0]};
      cur = upd(OPS[3*(j/4) +: 3], cur, v);
      @(posedge CLK);
      upd_op <= OPS[3*(j/4) +: 3];
      per_res <= {~v, seed, v};
      per_end <= 1'b1;
      @(posedge CLK);
      per_end <= 1'b0;
      rd(1'b0);
      check(bval[31:0], cur);
      check(bval[63:32], cur);
    end
    @(posedge CLK);
    ext <= 1'b1;
    repeat (3) @(posedge CLK);
    ext <= 1'b0;
    repeat (12) @(posedge CLK);
    alarm <= 1'b1;
    per_res <= {64'h0, 32'h1};
    per_end <= 1'b1;
    @(posedge CLK);
    alarm <= 1'b0;
    per_end <= 1'b0;
    repeat (4) @(posedge CLK);
    rd(1'b1);
    check(bval[31:0], cur + 32'h1);
    check(bval[63:32], cur);
    rd(1'b0);
    check(bval[31:0], 32'h0);
    check(bval[63:32], cur + 32'h1);
    @(posedge CLK);
    bank_type <= 2'h3;
    upd_op <= `MRB_UPD_WRITE;
    per_res <= {64'h0, 32'h64};
    per_end <= 1'b1;
    @(posedge CLK);
    per_end <= 1'b0;
    repeat (60) @(posedge CLK);
    rd(1'b0);
    check(bval[31:0], 32'h190);
    check(bval[63:32], 32'h190);
  endtask
  initial begin
    hyst_phase(32'h0);
    hyst_phase(32'h5);
    scale_phase;
    bank_phase;
    summarize;
  end
endmodule // mrb_engine_test

// *** tb/mrb_pulse_gen.sv ***
`timescale 1ns/100ps
module mrb_pulse_gen (
  input wire CLK, // Clock
  input wire RESETN, // Reset
  input wire REQ, // Pulse request
  input wire [3:0] GAP, // Idle cycles after a pulse, beyond the first
  output reg ACK, // Pulse taken
  output reg [15:0] COUNT // Pulses issued
);
  reg [3:0] wait_cnt;
  always @(posedge CLK) begin
    if (!RESETN) begin
      ACK <= 1'b0;
      wait_cnt <= 4'h0;
      COUNT <= 16'h0;
    end else if (ACK) begin
      ACK <= 1'b0;
      wait_cnt <= GAP;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (REQ) begin
      ACK <= 1'b1;
      COUNT <= COUNT + 16'h1;
    end
  end
endmodule // mrb_pulse_gen
